// ==== design/pid_regulator_ext.sv ====
// Purpose: Process regulator extension with gain switching, start hold,
//   output step limiting, integral options and feedback loss detection
// Assumes: Setting, feedback and run come from logic on core_clk
// Notes: APB slave, one wait state on every access
//
// Overview of operation
// RULE1: Switch condition 0 keeps gain set 1, 1 follows the switch pin, 2 switches on deviation.
// RULE2: In pin mode the switch pin off selects gain set 1 and on selects gain set 2.
// RULE3: In auto mode a deviation below the low threshold selects gain set 1.
// RULE4: In auto mode a deviation above the high threshold selects gain set 2.
// RULE5: In auto mode a deviation between the thresholds blends both sets linearly.
// RULE6: At drive start the output holds the initial value for the hold time, then regulates.
// RULE7: The change between successive outputs is capped by forward and reverse maxima.
// RULE8: Integral option units digit 0 disables and 1 enables integral separation.
// RULE9: With separation enabled the pause pin freezes the integral term.
// RULE10: With separation disabled the integral runs whatever the pause pin does.
// RULE11: Integral option tens digit 1 stops integration while the output is at its limit.
// RULE12: Feedback below the loss level for longer than the loss time raises the loss fault.
// RULE13: A loss level of zero disables loss checking.
// RULE14: Run-at-stop 0 halts the calculation while stopped, 1 keeps it running.
// RULE15: Deviation and terms are recomputed once per fixed control period.

`timescale 1ns/1ns
`default_nettype none

module pid_regulator_ext
  import pid_reg_pkg::*;
#(
  parameter int CTRL_PERIOD_CYC = CTRL_PERIOD_CYC_DEF
)(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Process side
  input wire logic [15:0] setting,
  input wire logic [15:0] feedback,
  input wire logic drive_running,
  // Terminal pins
  input wire logic gain_switch_pin,
  input wire logic integral_pause_pin,
  // Drive side
  output logic [15:0] freq_ref,
  output logic feedback_loss_fault
);

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  // Q8.8 gain times signed value
  function automatic logic signed [31:0] mulq(input logic signed [31:0] a,
                                              input logic [15:0] g);
    logic signed [48:0] m;
    m = a * $signed({1'b0, g});
    mulq = m[39:8];
  endfunction

  // Saturate to a signed range
  function automatic logic signed [31:0] clamp(input logic signed [31:0] x,
                                               input logic signed [31:0] lo,
                                               input logic signed [31:0] hi);
    clamp = (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction

  // Gain of the selected set or the blend of both
  function automatic logic [15:0] pick(input logic [15:0] g1, input logic [15:0] g2,
                                       input logic [1:0] sel, input logic [8:0] f);
    logic signed [27:0] m;
    m = ($signed({1'b0, g2}) - $signed({1'b0, g1})) * $signed({1'b0, f});
    case (sel)
      GSEL_SET2: pick = g2;
      GSEL_BLEND: pick = 16'(g1 + m[23:8]);
      default: pick = g1;
    endcase
  endfunction

  // Absolute value of a deviation
  function automatic logic [15:0] absdev(input logic signed [16:0] e);
    absdev = e[16] ? 16'(-e) : e[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [15:0] regs_ff [0:NUM_RW-1];
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic gsw_s1_ff, gsw_s2_ff, pause_s1_ff, pause_s2_ff;
  logic run_d_ff;
  logic [15:0] period_cnt_ff;
  ctrl_state_t state_ff, nxt_state;
  logic signed [16:0] err_ff, errprev_ff;
  logic signed [31:0] integ_ff;
  logic [15:0] out_ff;
  logic [8:0] frac_ff;
  logic [1:0] gsel_ff;
  logic [23:0] hold_cnt_ff, loss_cnt_ff;
  logic fault_ff;
  logic div_done;
  logic [23:0] div_quo;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire logic [4:0] idx = paddr[6:2];
  wire logic apb_hit = ~paddr[7] & (idx <= IDX_OUTPUT);
  wire logic apb_access = psel & penable;
  wire logic wr_fire = apb_access & pready_ff & pwrite & apb_hit;
  wire logic [15:0] status_word = {12'h000, (hold_cnt_ff != 24'h00_0000), gsel_ff, fault_ff};
  wire logic [15:0] rd_half = (idx < 5'(NUM_RW)) ? regs_ff[idx] :
                              (idx == IDX_STATUS) ? status_word :
                              (idx == IDX_OUTPUT) ? out_ff : 16'h0000;

  // Answer one cycle after the access phase opens
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff <= apb_access & ~pready_ff;
      if (apb_access & ~pready_ff) begin
        pslverr_ff <= ~apb_hit;
        prdata_ff <= (pwrite | ~apb_hit) ? 32'h0000_0000 : {16'h0000, rd_half};
      end
    end
  end

  // Register array writes
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NUM_RW; i++) begin
      if (!nrst) begin
        regs_ff[i] <= RST_VAL[i];
      end else if (ce && wr_fire && idx == 5'(i)) begin
        regs_ff[i] <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields
  wire logic [1:0] cond = regs_ff[IDX_GAIN_COND][1:0];
  wire logic [15:0] dev_low = regs_ff[IDX_DEV_LOW];
  wire logic [15:0] dev_high = regs_ff[IDX_DEV_HIGH];
  wire logic sep_en = regs_ff[IDX_INT_OPT][INTOPT_SEP_BIT];
  wire logic stop_at_limit = regs_ff[IDX_INT_OPT][INTOPT_STOP_BIT];
  wire logic [15:0] loss_level = regs_ff[IDX_LOSS_LEVEL];
  wire logic run_at_stop = regs_ff[IDX_RUN_STOP][0];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      gsw_s1_ff <= 1'b0;
      gsw_s2_ff <= 1'b0;
      pause_s1_ff <= 1'b0;
      pause_s2_ff <= 1'b0;
    end else if (ce) begin
      gsw_s1_ff <= gain_switch_pin;
      gsw_s2_ff <= gsw_s1_ff;
      pause_s1_ff <= integral_pause_pin;
      pause_s2_ff <= pause_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period tick and control sequence
  wire logic tick = period_cnt_ff == 16'(CTRL_PERIOD_CYC - 1);
  wire logic calc_en = drive_running | run_at_stop; // see RULE14
  wire logic start_edge = drive_running & ~run_d_ff;
  wire logic div_start = (state_ff == ST_IDLE) & tick & calc_en; // see RULE15

  // Deviation sampled at the period start
  wire logic signed [16:0] err_live = $signed({1'b0, setting}) - $signed({1'b0, feedback});
  wire logic [15:0] dev_live = absdev(err_live);
  wire logic [15:0] dev = absdev(err_ff);
  wire logic [23:0] div_num = {16'(dev_live - dev_low), 8'h00};
  wire logic [15:0] div_den = 16'(dev_high - dev_low);

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (div_start) nxt_state = ST_DIV;
      ST_DIV: if (div_done) nxt_state = ST_CALC;
      ST_CALC: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // State, tick counter, run edge, sampled deviation
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      period_cnt_ff <= 16'h0000;
      run_d_ff <= 1'b0;
      err_ff <= 17'h0_0000;
      frac_ff <= 9'h000;
    end else if (ce) begin
      state_ff <= nxt_state;
      period_cnt_ff <= tick ? 16'h0000 : 16'(period_cnt_ff + 16'h0001);
      run_d_ff <= drive_running;
      if (div_start) err_ff <= err_live;
      if (div_done) frac_ff <= (div_quo > {15'h0000, FRAC_ONE}) ? FRAC_ONE : div_quo[8:0];
    end
  end

  // Blend fraction of the deviation between thresholds
  pid_divider u_div (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .start(div_start),
    .dividend(div_num),
    .divisor(div_den),
    .done_ff(div_done),
    .quotient_ff(div_quo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Gain set choice
  wire logic [1:0] gsel_auto = (dev < dev_low) ? GSEL_SET1 : // see RULE3
                               (dev > dev_high) ? GSEL_SET2 : // see RULE4
                               GSEL_BLEND; // see RULE5
  wire logic [1:0] gsel = (cond == COND_PIN) ? (gsw_s2_ff ? GSEL_SET2 : GSEL_SET1) : // see RULE2
                          (cond == COND_AUTO) ? gsel_auto : GSEL_SET1; // see RULE1
  wire logic [15:0] kp = pick(regs_ff[IDX_KP1], regs_ff[IDX_KP2], gsel, frac_ff);
  wire logic [15:0] ki = pick(regs_ff[IDX_KI1], regs_ff[IDX_KI2], gsel, frac_ff);
  wire logic [15:0] kd = pick(regs_ff[IDX_KD1], regs_ff[IDX_KD2], gsel, frac_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Terms, integral options, step limit
  wire logic signed [31:0] fs32 = $signed({16'h0000, FULL_SCALE});
  wire logic signed [31:0] err32 = 32'(err_ff);
  wire logic signed [31:0] p_term = mulq(err32, kp);
  wire logic signed [31:0] i_inc = mulq(err32, ki);
  wire logic signed [31:0] d_term = mulq(32'(err_ff - errprev_ff), kd);
  wire logic signed [31:0] sum_pre = p_term + integ_ff + d_term;
  wire logic at_limit = (sum_pre < 0) | (sum_pre > fs32);
  wire logic int_run = ~(sep_en & pause_s2_ff) & // see RULE8, RULE9, RULE10
                       ~(stop_at_limit & at_limit); // see RULE11
  wire logic signed [31:0] integ_nxt = int_run ? clamp(integ_ff + i_inc, -fs32, fs32)
                                               : integ_ff;
  wire logic signed [31:0] raw = clamp(p_term + integ_nxt + d_term, 0, fs32);
  wire logic signed [31:0] out32 = $signed({16'h0000, out_ff});
  wire logic signed [31:0] fwd32 = $signed({16'h0000, regs_ff[IDX_FWD_STEP]});
  wire logic signed [31:0] rev32 = $signed({16'h0000, regs_ff[IDX_REV_STEP]});
  wire logic signed [31:0] delta = raw - out32;
  wire logic signed [31:0] limited = (delta > fwd32) ? out32 + fwd32 : // see RULE7
                                     (delta < -rev32) ? out32 - rev32 : raw;

  // Output, integral and hold update
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      out_ff <= 16'h0000;
      integ_ff <= 32'h0000_0000;
      errprev_ff <= 17'h0_0000;
      hold_cnt_ff <= 24'h00_0000;
      gsel_ff <= GSEL_SET1;
    end else if (ce) begin
      if (start_edge) begin
        out_ff <= regs_ff[IDX_INIT_OUT]; // see RULE6
        integ_ff <= 32'h0000_0000;
        hold_cnt_ff <= 24'({8'h00, regs_ff[IDX_HOLD_TIME]} * HOLD_UNIT_PERIODS); // see RULE6
      end else if (state_ff == ST_CALC) begin
        errprev_ff <= err_ff;
        gsel_ff <= gsel;
        if (hold_cnt_ff != 24'h00_0000) begin
          hold_cnt_ff <= 24'(hold_cnt_ff - 24'h00_0001); // see RULE6
          out_ff <= regs_ff[IDX_INIT_OUT];
        end else begin
          out_ff <= limited[15:0]; // see RULE15
          integ_ff <= integ_nxt;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feedback loss watch
  wire logic loss_active = (loss_level != 16'h0000) & (feedback < loss_level); // see RULE13
  wire logic [23:0] loss_limit = 24'({8'h00, regs_ff[IDX_LOSS_TIME]} * LOSS_UNIT_PERIODS);
  wire logic loss_over = loss_cnt_ff > loss_limit;
  wire logic fault_clr = wr_fire & (idx == IDX_STATUS) & pwdata[STAT_FAULT_BIT];

  // Loss counter and sticky fault, set wins over clear
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      loss_cnt_ff <= 24'h00_0000;
      fault_ff <= 1'b0;
    end else if (ce) begin
      if (tick) begin
        if (!loss_active) loss_cnt_ff <= 24'h00_0000;
        else if (!loss_over) loss_cnt_ff <= 24'(loss_cnt_ff + 24'h00_0001);
      end
      if (tick & loss_active & loss_over) fault_ff <= 1'b1; // see RULE12
      else if (fault_clr) fault_ff <= 1'b0;
    end
  end

  // Outputs
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign freq_ref = out_ff;
  assign feedback_loss_fault = fault_ff;

endmodule

`default_nettype wire

// ==== include/pid_reg_pkg.sv ====
// Purpose: Shared constants for the process regulator extension block
// Assumes: Percent values in 0.01 % steps, full scale 10000; gains in Q8.8
// Notes: Register byte address is four times the register index

package pid_reg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices (byte address = index * 4)
  localparam logic [4:0] IDX_GAIN_COND = 5'h00;
  localparam logic [4:0] IDX_DEV_LOW = 5'h01;
  localparam logic [4:0] IDX_DEV_HIGH = 5'h02;
  localparam logic [4:0] IDX_KP1 = 5'h03;
  localparam logic [4:0] IDX_KI1 = 5'h04;
  localparam logic [4:0] IDX_KD1 = 5'h05;
  localparam logic [4:0] IDX_KP2 = 5'h06;
  localparam logic [4:0] IDX_KI2 = 5'h07;
  localparam logic [4:0] IDX_KD2 = 5'h08;
  localparam logic [4:0] IDX_INIT_OUT = 5'h09;
  localparam logic [4:0] IDX_HOLD_TIME = 5'h0a;
  localparam logic [4:0] IDX_FWD_STEP = 5'h0b;
  localparam logic [4:0] IDX_REV_STEP = 5'h0c;
  localparam logic [4:0] IDX_INT_OPT = 5'h0d;
  localparam logic [4:0] IDX_LOSS_LEVEL = 5'h0e;
  localparam logic [4:0] IDX_LOSS_TIME = 5'h0f;
  localparam logic [4:0] IDX_RUN_STOP = 5'h10;
  localparam logic [4:0] IDX_STATUS = 5'h11;
  localparam logic [4:0] IDX_OUTPUT = 5'h12;
  localparam int NUM_RW = 17;

  // Reset values of the writable registers, by index
  localparam logic [15:0] RST_VAL [0:NUM_RW-1] = '{
    16'h0000, 16'h07d0, 16'h1f40, 16'h1400, 16'h0010, 16'h0000,
    16'h1400, 16'h0010, 16'h0000, 16'h0000, 16'h0000, 16'h0064,
    16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0001};

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and codes
  localparam int INTOPT_SEP_BIT = 0;
  localparam int INTOPT_STOP_BIT = 4;
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_HOLD_BIT = 3;
  localparam logic [1:0] COND_NONE = 2'h0;
  localparam logic [1:0] COND_PIN = 2'h1;
  localparam logic [1:0] COND_AUTO = 2'h2;
  localparam logic [1:0] GSEL_SET1 = 2'h0;
  localparam logic [1:0] GSEL_SET2 = 2'h1;
  localparam logic [1:0] GSEL_BLEND = 2'h2;
  localparam logic [15:0] FULL_SCALE = 16'h2710;
  localparam logic [8:0] FRAC_ONE = 9'h100;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 25;
  localparam int CTRL_PERIOD_US = 1000;
  localparam int CTRL_PERIOD_CYC_DEF = CTRL_PERIOD_US * CLK_MHZ;
  localparam int HOLD_UNIT_US = 10000;
  localparam int LOSS_UNIT_US = 100000;
  localparam logic [23:0] HOLD_UNIT_PERIODS = 24'(HOLD_UNIT_US / CTRL_PERIOD_US);
  localparam logic [23:0] LOSS_UNIT_PERIODS = 24'(LOSS_UNIT_US / CTRL_PERIOD_US);
  localparam int DIV_STEPS = 24;

  // Control sequence states, Gray coded
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV = 2'b01,
    ST_CALC = 2'b11
  } ctrl_state_t;

endpackage

// ==== design/pid_divider.sv ====
// Purpose: Serial restoring divider for the gain blend fraction
// Assumes: Operands stay valid only at the start pulse; they are captured
// Notes: One quotient bit per enabled cycle; zero divisor gives all ones

`timescale 1ns/1ns
`default_nettype none

module pid_divider
  import pid_reg_pkg::*;
(
  // Clock and control
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Request
  input wire logic start,
  input wire logic [23:0] dividend,
  input wire logic [15:0] divisor,
  // Answer
  output logic done_ff,
  output logic [23:0] quotient_ff
);

  logic [15:0] rem_ff;
  logic [15:0] den_ff;
  logic [4:0] cnt_ff;
  logic busy_ff;
  logic [16:0] trial;
  logic fits;

  // One restoring step
  assign trial = {rem_ff, quotient_ff[23]};
  assign fits = trial >= {1'b0, den_ff};

  // Iteration control
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rem_ff <= 16'h0000;
      den_ff <= 16'h0000;
      cnt_ff <= 5'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      quotient_ff <= 24'h00_0000;
    end else if (ce) begin
      done_ff <= 1'b0;
      if (start) begin
        rem_ff <= 16'h0000;
        den_ff <= divisor;
        quotient_ff <= dividend;
        cnt_ff <= 5'(DIV_STEPS - 1);
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        rem_ff <= fits ? 16'(trial - {1'b0, den_ff}) : trial[15:0];
        quotient_ff <= {quotient_ff[22:0], fits};
        cnt_ff <= 5'(cnt_ff - 5'h01);
        if (cnt_ff == 5'h00) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== tb/pid_ext_checker.sv ====
// Purpose: Port checker for the regulator extension
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to the design top after the module
`timescale 1ns/1ns
`default_nettype none

module pid_ext_checker
  import pid_reg_pkg::*;
(
  // Clock and control
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Drive side
  input wire logic drive_running,
  input wire logic [15:0] freq_ref,
  input wire logic feedback_loss_fault
);
  ////////////////////////////////////////////////////////////
  // Drive start marker and fault clear strobe
  logic run_ff;
  wire logic start_now;
  wire logic clr_now;
  always_ff @(posedge core_clk) begin
    run_ff <= drive_running;
  end
  assign start_now = drive_running & ~run_ff;
  assign clr_now = psel & penable & pready & pwrite & (paddr == {1'b0, IDX_STATUS, 2'b00}) &
                   pwdata[STAT_FAULT_BIT];

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // APB answer timing, decoding and refused data
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready high for more than one cycle");
  ready_wait_a: assert property (psel && penable && $past(psel && !penable) |-> !pready ##1 pready)
    else $error("pready not after exactly one wait state");
  err_decode_a: assert property (pready |-> pslverr == (paddr[7] || paddr[6:2] > IDX_OUTPUT))
    else $error("pslverr does not match the address decode");
  err_data_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned nonzero data");
  // Output range and pacing
  ref_range_a: assert property (freq_ref <= FULL_SCALE)
    else $error("output above full scale");
  ref_period_a: assert property ($changed(freq_ref) |=>
    ($stable(freq_ref) || start_now || $past(start_now))[*8])
    else $error("output changed twice within one period");
  // Fault stays until written clear, and clock enable freezes state
  fault_sticky_a: assert property (feedback_loss_fault && !clr_now |=> feedback_loss_fault)
    else $error("loss fault dropped without a clear");
  freeze_ce_a: assert property (!ce |=> $stable(freq_ref) && $stable(feedback_loss_fault))
    else $error("state moved with clock enable low");

  cover property ($rose(feedback_loss_fault));
  cover property (pready && pslverr);
  cover property ($changed(freq_ref) && drive_running);
endmodule

bind pid_regulator_ext pid_ext_checker chk (
  .core_clk(core_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .drive_running(drive_running), .freq_ref(freq_ref),
  .feedback_loss_fault(feedback_loss_fault));

`default_nettype wire

// ==== tb/process_feed_model.sv ====
// Purpose: Process feedback source facing the regulator
// Assumes: Bench commands the level and the speed of change
// Notes: Slow mode creeps one count per cycle

`timescale 1ns/1ns
`default_nettype none

module process_feed_model (
  // Clock
  input wire logic core_clk,
  // Commands
  input wire logic [15:0] fb_cmd,
  input wire logic slow,
  // Process value
  output logic [15:0] feedback
);
  initial feedback = 16'h0000;
  // Jump at once or creep towards the commanded level
  always @(posedge core_clk) begin
    if (!slow || feedback == fb_cmd) feedback <= fb_cmd;
    else if (feedback < fb_cmd) feedback <= feedback + 16'h0001;
    else feedback <= feedback - 16'h0001;
  end
endmodule

`default_nettype wire

// ==== tb/test_process_pid_regulator_ext.sv ====
// Purpose: Self-checking bench for the regulator extension
// Assumes: Short control period of 40 cycles
// Notes: Unity and double proportional gains; integral action only in the last section

`timescale 1ns/1ns
`default_nettype none

module test_process_pid_regulator_ext
  import pid_reg_pkg::*;
;
  localparam int PER = 40;
  logic core_clk, nrst, ce, psel, penable, pwrite, drive_running, sw_pin, pause_pin, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, fault, err_seen;
  logic [15:0] setting, feedback, fb_cmd, freq_ref;
  int bad_count, n_checks, m_prev, m_tgt, lim_f, lim_r, r;
  bit mon;
  int t_cond[6] = '{0, 1, 1, 2, 2, 2};
  int t_pin[6] = '{1, 1, 0, 0, 0, 0};
  int t_err[6] = '{3000, 3000, 3000, 1000, 9000, 5000};
  int t_sel[6] = '{0, 1, 0, 0, 1, 2};

  pid_regulator_ext #(.CTRL_PERIOD_CYC(PER)) DUT (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .setting(setting), .feedback(feedback),
    .drive_running(drive_running), .gain_switch_pin(sw_pin),
    .integral_pause_pin(pause_pin), .freq_ref(freq_ref), .feedback_loss_fault(fault));
  process_feed_model PM (.core_clk(core_clk), .fb_cmd(fb_cmd), .slow(slow), .feedback(feedback));

  ////////////////////////////////////////////////////////////
  // Compare, verdict, bus cycles
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [4:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {1'h0, idx, 2'h0};
    pwdata <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
    if (n >= 20) bad_count++;
  endtask
  task automatic wr(input logic [4:0] idx, input int d);
    apb(1'h1, idx, d[15:0]);
  endtask
  task automatic per(input int k);
    repeat (k * PER) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////
  // Reference model: clamp, gain choice and step limit
  function automatic int clamp(int v);
    return (v < 0) ? 0 : ((v > int'(FULL_SCALE)) ? int'(FULL_SCALE) : v);
  endfunction
  function automatic int gain_of(int sel, int e);
    if (sel == 0) return 256;
    if (sel == 1) return 512;
    return 256 + (e - 2000) * 256 / 6000;
  endfunction
  function automatic int step(int p, int t);
    if (t > p + lim_f) return p + lim_f;
    if (t < p - lim_r) return p - lim_r;
    return t;
  endfunction
  // Every output change while mon is set is checked against the model
  always @(posedge core_clk) begin
    if (mon && freq_ref !== m_prev[15:0]) begin
      check(freq_ref, step(m_prev, m_tgt));
      m_prev = freq_ref;
    end
  end

  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #(40 * 12000);
    bad_count++;
    stop_test;
  end

  ////////////////////////////////////////////////////////////
  initial begin
    {nrst, psel, penable, pwrite, drive_running, sw_pin, pause_pin, slow} = '0;
    ce = 1'h1;
    paddr = '0;
    pwdata = '0;
    setting = '0;
    fb_cmd = '0;
    void'($urandom(80));
    repeat (5) @(posedge core_clk);
    nrst <= 1'h1;
    @(posedge core_clk);
    // Reset values, then a refused index
    for (int i = 0; i < NUM_RW; i++) begin
      apb(1'h0, 5'(i), 16'h0000);
      check(rd, {16'h0000, RST_VAL[i]});
    end
    apb(1'h0, 5'h13, 16'h0000);
    check(err_seen, 1);
    check(rd, 0);
    // Unity and double gains, start value 500 held ten periods
    wr(IDX_KP1, 256);
    wr(IDX_KP2, 512);
    wr(IDX_KI1, 0);
    wr(IDX_KI2, 0);
    wr(IDX_INIT_OUT, 500);
    wr(IDX_HOLD_TIME, 1);
    r = 2000 + $urandom % 2000;
    fb_cmd <= 16'h03e8;
    setting <= 16'(1000 + r);
    per(2);
    drive_running <= 1'h1;
    repeat (3) @(posedge core_clk);
    check(freq_ref, 500);
    m_prev = 500;
    m_tgt = r;
    lim_f = 100;
    lim_r = 100;
    mon = 1;
    per(8);
    check(freq_ref, 500);
    per(12);
    check(freq_ref > 500, 1);
    // Fall towards a lower target in reverse steps
    mon = 0;
    setting <= 16'h05dc;
    per(2);
    m_prev = freq_ref;
    m_tgt = 500;
    mon = 1;
    per(10);
    mon = 0;
    // Gain set choice by code, pin and deviation
    wr(IDX_FWD_STEP, 10000);
    wr(IDX_REV_STEP, 10000);
    fb_cmd <= 16'h01f4;
    foreach (t_cond[k]) begin
      wr(IDX_GAIN_COND, t_cond[k]);
      sw_pin <= t_pin[k][0];
      pause_pin <= 1'($urandom);
      setting <= 16'(500 + t_err[k]);
      per(3);
      check(freq_ref, clamp(gain_of(t_sel[k], t_err[k]) * t_err[k] / 256));
      apb(1'h0, IDX_STATUS, 16'h0000);
      check(rd[2:1], t_sel[k]);
    end
    // Stopped: frozen with run-at-stop off, follows with it on
    wr(IDX_RUN_STOP, 0);
    drive_running <= 1'h0;
    setting <= 16'h05dc;
    per(3);
    check(freq_ref, 7500);
    wr(IDX_RUN_STOP, 1);
    per(3);
    check(freq_ref, 1000);
    // Feedback decays slowly; level zero never faults
    slow <= 1'h1;
    fb_cmd <= 16'h0000;
    per(15);
    check(fault, 0);
    ce <= 1'h0;
    repeat (3) @(posedge core_clk);
    ce <= 1'h1;
    wr(IDX_LOSS_LEVEL, 1000);
    per(4);
    check(fault, 1);
    slow <= 1'h0;
    fb_cmd <= 16'h1388;
    per(2);
    wr(IDX_STATUS, 1);
    per(2);
    check(fault, 0);
    // Integral only: pause with separation, pause ignored; KP1 back to unity for stop at limit
    pause_pin <= 1'h1;
    wr(IDX_INT_OPT, 1 << INTOPT_SEP_BIT);
    wr(IDX_KP1, 0);
    wr(IDX_KI1, 256);
    wr(IDX_GAIN_COND, 0);
    setting <= 16'h13ec;
    per(3);
    check(freq_ref, 0);
    wr(IDX_INT_OPT, 0);
    per(3);
    check(freq_ref > 0, 1);
    wr(IDX_INT_OPT, 1 << INTOPT_STOP_BIT);
    wr(IDX_KP1, 256);
    setting <= 16'h2710;
    per(3);
    setting <= 16'h1388;
    per(3);
    check(freq_ref < FULL_SCALE, 1);
    stop_test;
  end
endmodule

`default_nettype wire
